// >>> hdl/uss_err_fifo.sv
// Error tags that travel with each character held in the receive FIFO.
`timescale 1ns/100ps
`include "uss_params.svh"
module uss_err_fifo import uss_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic push,
  input wire logic push_fe,
  input wire logic push_pe,
  input wire logic pop,
  output logic [4:0] count,
  output logic head_fe,
  output logic head_pe,
  output logic [3:0] fe_cnt,
  output logic [3:0] pe_cnt
);
  logic [1:0] tag_mem [16];
  logic [3:0] wp_ff, rp_ff;
  logic [4:0] cnt_ff, fe_ff, pe_ff;
  wire do_push = push & (cnt_ff != `USS_FIFO_DEPTH);
  wire do_pop = pop & (cnt_ff != 5'd0);
  wire [1:0] head = (cnt_ff != 5'd0) ? tag_mem[rp_ff] : 2'b00;

  // A field of four bits cannot show sixteen, so it saturates.
  function automatic logic [3:0] sat4(input logic [4:0] v);
    return v[4] ? 4'hf : v[3:0];
  endfunction

  always_ff @(posedge aclk) begin
    if (do_push) begin
      tag_mem[wp_ff] <= {push_fe, push_pe};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      wp_ff <= 4'h0;
      rp_ff <= 4'h0;
      cnt_ff <= 5'h00;
      fe_ff <= 5'h00;
      pe_ff <= 5'h00;
    end else begin
      wp_ff <= wp_ff + {3'h0, do_push};
      rp_ff <= rp_ff + {3'h0, do_pop};
      cnt_ff <= cnt_ff + {4'h0, do_push} - {4'h0, do_pop};
      fe_ff <= fe_ff + {4'h0, do_push & push_fe} - {4'h0, do_pop & head[1]};
      pe_ff <= pe_ff + {4'h0, do_push & push_pe} - {4'h0, do_pop & head[0]};
    end
  end

  assign count = cnt_ff;
  assign head_fe = head[1];
  assign head_pe = head[0];
  assign fe_cnt = sat4(fe_ff);
  assign pe_cnt = sat4(pe_ff);
endmodule // uss_err_fifo

// >>> hdl/uss_status.sv
// Status flags, transmit count and register slave of the FIFO serial port.
//
// Notes on behaviour
// - Status is 16 bits: upper byte error counts, lower byte operating flags.
// - Flags 7,6,5,4,1,0 accept only 0, and only after being read as 1.
// - Bits 3 and 2 are read-only; writes to them are ignored.
// - Reset, standby and module standby load status with 0x0060.
// - A zero in the checked stop bit sets the receive fault flag.
// - With parity on, a parity mismatch sets the receive fault flag.
// - Clearing receive enable leaves the receive fault flag as it was.
// - Errored characters still enter the receive FIFO; reception continues.
// - Only the first stop bit is checked for framing.
// - Transmit done sets when last bit leaves empty FIFO, on reset, on disable.
// - Writing a transmit byte clears transmit done.
// - Transmit low flag sets on reset and when a load drops count below trigger.
// - Transmit low clears when filled beyond trigger, or read 1 then write 0.
// - Transmit FIFO holds 16 bytes; a byte written while full is dropped.
// - Software can read the transmit FIFO byte count in a 5-bit field.
// - Break sets on a framing error, or framing error followed by space.
// - Break clears on reset, standby, or read 1 then write 0.
// - Frame and parity bits show the error state of the FIFO head character.
// - Receive full sets above trigger; clears below trigger after read 1, write 0.
// - Idle flag sets below trigger when 15 etu pass with no new character.
// - Bits 15..12 count parity errors and 11..8 framing errors in the FIFO.
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "uss_params.svh"
module uss_status import uss_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic standby,
  input wire logic module_standby,
  input wire logic rx_line,
  input wire logic etu_tick,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  input wire logic rx_parity_bit,
  input wire logic rx_stop_bit,
  input wire logic rx_pop,
  input wire logic tx_load,
  input wire logic tx_char_end,
  output logic tx_push,
  output logic [7:0] tx_fifo_data,
  output logic tx_enable_bit,
  output logic rx_enable_bit,
  output logic two_stop,
  output logic parity_enable,
  output logic parity_odd_select
);
  ////////////////////////////////////////////////////////////////////////////
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_got_ff, w_got_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [7:0] flag_ff, armed_ff, ctrl_ff;
  logic [11:0] trig_ff;
  logic [4:0] txcnt_ff;
  logic tx_push_ff;
  logic [7:0] tx_byte_ff;
  logic [3:0] idle_cnt_ff;
  logic idle_run_ff, fe_hold_ff, line_prev_ff;
  logic line_s;
  logic [4:0] rxcnt;
  logic head_fe, head_pe;
  logic [3:0] fe_cnt, pe_cnt;

  function automatic uss_reg_type reg_sel(input logic [7:0] addr);
    case (addr)
      `USS_OFF_STATUS: return USS_REG_STATUS;
      `USS_OFF_CTRL: return USS_REG_CTRL;
      `USS_OFF_TRIG: return USS_REG_TRIG;
      `USS_OFF_TXDATA: return USS_REG_TXDATA;
      default: return USS_REG_NONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write path: address and data are taken in either order, then one answer.
  wire aw_hs = s_axi_awvalid & awready_ff;
  wire w_hs = s_axi_wvalid & wready_ff;
  wire b_hs = bvalid_ff & s_axi_bready;
  wire do_write = aw_got_ff & w_got_ff & ~bvalid_ff;
  wire uss_reg_type wsel = reg_sel(awaddr_ff);
  wire wr_lo = do_write & wstrb_ff[0];
  wire wr_status = wr_lo & (wsel == USS_REG_STATUS);
  wire wr_ctrl = wr_lo & (wsel == USS_REG_CTRL);
  wire wr_trig = do_write & (wsel == USS_REG_TRIG);
  wire wr_tx = wr_lo & (wsel == USS_REG_TXDATA);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `USS_RESP_OKAY;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (aw_hs) begin
        awready_ff <= 1'b0;
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        wready_ff <= 1'b0;
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (wsel == USS_REG_NONE) ? `USS_RESP_SLVERR : `USS_RESP_OKAY;
      end
      if (b_hs) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: data is captured at the address handshake.
  wire ar_hs = s_axi_arvalid & arready_ff;
  wire uss_reg_type rsel = reg_sel(s_axi_araddr);
  wire [15:0] status_w = {pe_cnt, fe_cnt, flag_ff[7:4], head_fe, head_pe,
                          flag_ff[1:0]};
  wire rd_status = ar_hs & (rsel == USS_REG_STATUS);
  logic [31:0] rd_word;

  always_comb begin
    case (rsel)
      USS_REG_STATUS: rd_word = {16'h0000, status_w};
      USS_REG_CTRL: rd_word = {24'h00_0000, ctrl_ff};
      USS_REG_TRIG: rd_word = {20'h0_0000, trig_ff};
      USS_REG_TXDATA: rd_word = {16'h0000, 3'b000, rxcnt, 3'b000, txcnt_ff};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `USS_RESP_OKAY;
    end else if (ar_hs) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= (rsel == USS_REG_NONE) ? `USS_RESP_SLVERR : `USS_RESP_OKAY;
    end else if (rvalid_ff & s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive side: error checks, error tags, break and idle timing.
  wire stby = standby | module_standby;
  wire rx_char = rx_char_valid & ctrl_ff[`USS_CTRL_RE];
  wire char_fe = ~rx_stop_bit;
  wire par_odd = ^{rx_char_data, rx_parity_bit};
  wire char_pe = ctrl_ff[`USS_CTRL_PEN] & (par_odd != ctrl_ff[`USS_CTRL_ODD]);
  wire start_edge = line_prev_ff & ~line_s;
  wire below_rx = rxcnt < {1'b0, trig_ff[`USS_TRIG_RX]};
  wire above_rx = rxcnt > {1'b0, trig_ff[`USS_TRIG_RX]};
  wire idle_hit = idle_run_ff & etu_tick & (idle_cnt_ff == `USS_IDLE_ETU - 4'd1);

  uss_sync3 u_line_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(rx_line),
    .q(line_s)
  );

  // Errored characters are tagged, not dropped, so reception never stalls.
  uss_err_fifo u_err_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(stby),
    .push(rx_char),
    .push_fe(rx_char & char_fe),
    .push_pe(rx_char & char_pe),
    .pop(rx_pop),
    .count(rxcnt),
    .head_fe(head_fe),
    .head_pe(head_pe),
    .fe_cnt(fe_cnt),
    .pe_cnt(pe_cnt)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn || stby) begin
      idle_cnt_ff <= 4'h0;
      idle_run_ff <= 1'b0;
      fe_hold_ff <= 1'b0;
      line_prev_ff <= 1'b1;
    end else begin
      line_prev_ff <= line_s;
      if (rx_char) begin
        idle_cnt_ff <= 4'h0;
        idle_run_ff <= 1'b1;
      end else if (start_edge || idle_hit) begin
        idle_run_ff <= 1'b0;
      end else if (idle_run_ff && etu_tick) begin
        idle_cnt_ff <= idle_cnt_ff + 4'h1;
      end
      if (rx_char) begin
        fe_hold_ff <= char_fe;
      end else if (line_s) begin
        fe_hold_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit count; a byte offered to a full FIFO is simply not counted.
  wire tx_accept = wr_tx & (txcnt_ff != `USS_FIFO_DEPTH);
  wire tx_take = tx_load & (txcnt_ff != 5'd0);
  wire [4:0] nxt_txcnt = txcnt_ff + {4'h0, tx_accept} - {4'h0, tx_take};
  wire [4:0] tx_trig = {1'b0, trig_ff[`USS_TRIG_TX]};
  wire te_fall = wr_ctrl & ctrl_ff[`USS_CTRL_TE] & ~wdata_ff[`USS_CTRL_TE];

  ////////////////////////////////////////////////////////////////////////////
  // Flags: hardware set wins over any clear in the same cycle.
  logic [7:0] set_v, hw_clr_v, sw_clr_v, nxt_flag, nxt_armed;

  always_comb begin
    set_v = 8'h00;
    hw_clr_v = 8'h00;
    set_v[`USS_BIT_ER] = rx_char & (char_fe | char_pe);
    set_v[`USS_BIT_TX_DONE_FLAG] = (tx_char_end & (txcnt_ff == 5'd0)) | te_fall;
    set_v[`USS_BIT_TX_FIFO_LOW_FLAG] = tx_take & (nxt_txcnt < tx_trig);
    set_v[`USS_BIT_BRK] = (rx_char & char_fe) | (fe_hold_ff & ~line_s);
    set_v[`USS_BIT_RDF] = above_rx;
    set_v[`USS_BIT_DR] = idle_hit & below_rx & (rxcnt != 5'd0);
    hw_clr_v[`USS_BIT_TX_DONE_FLAG] = tx_accept;
    hw_clr_v[`USS_BIT_TX_FIFO_LOW_FLAG] = tx_accept & (nxt_txcnt > tx_trig);
    // Only a written zero on a flag that was read as one takes effect.
    sw_clr_v = {8{wr_status}} & ~wdata_ff[7:0] & armed_ff & `USS_CLR_MASK;
    sw_clr_v[`USS_BIT_RDF] = sw_clr_v[`USS_BIT_RDF] & below_rx;
    nxt_flag = (set_v | (flag_ff & ~(hw_clr_v | sw_clr_v))) & `USS_CLR_MASK;
    nxt_armed = (armed_ff | ({8{rd_status}} & flag_ff)) & nxt_flag;
  end

  // Standby reloads the same values as reset; receive enable never touches flags.
  always_ff @(posedge aclk) begin
    if (!aresetn || stby) begin
      flag_ff <= `USS_FLAG_RST;
      armed_ff <= 8'h00;
      ctrl_ff <= `USS_CTRL_RST;
      trig_ff <= `USS_TRIG_RST;
      txcnt_ff <= 5'h00;
      tx_push_ff <= 1'b0;
      tx_byte_ff <= 8'h00;
    end else begin
      flag_ff <= nxt_flag;
      armed_ff <= nxt_armed;
      txcnt_ff <= nxt_txcnt;
      tx_push_ff <= tx_accept;
      if (tx_accept) begin
        tx_byte_ff <= wdata_ff[7:0];
      end
      if (wr_ctrl) begin
        ctrl_ff <= wdata_ff[7:0] & `USS_CTRL_MASK;
      end
      if (wr_trig) begin
        trig_ff <= wdata_ff[11:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign tx_push = tx_push_ff;
  assign tx_fifo_data = tx_byte_ff;
  assign tx_enable_bit = ctrl_ff[`USS_CTRL_TE];
  assign rx_enable_bit = ctrl_ff[`USS_CTRL_RE];
  assign two_stop = ctrl_ff[`USS_CTRL_STOP2];
  assign parity_enable = ctrl_ff[`USS_CTRL_PEN];
  assign parity_odd_select = ctrl_ff[`USS_CTRL_ODD];

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  status_init_a: assert property (stby |=> status_w == `USS_STATUS_RST)
    else $error("status not reloaded by standby");
  no_blind_clear_a: assert property ($fell(flag_ff[`USS_BIT_BRK]) && !$past(stby)
    |-> $past(armed_ff[`USS_BIT_BRK]) && $past(wr_status))
    else $error("break flag cleared without read and zero write");
  frame_sets_er_a: assert property (rx_char && char_fe && !stby |=>
    flag_ff[`USS_BIT_ER] && flag_ff[`USS_BIT_BRK])
    else $error("framing error did not set flags");
  parity_sets_er_a: assert property (rx_char && char_pe && !stby |=> flag_ff[`USS_BIT_ER])
    else $error("parity error did not set flag");
  tx_write_clears_a: assert property (tx_accept && !set_v[`USS_BIT_TX_DONE_FLAG] && !stby
    |=> !flag_ff[`USS_BIT_TX_DONE_FLAG] && tx_push)
    else $error("accepted byte did not clear transmit done");
  tx_full_drop_a: assert property (txcnt_ff == `USS_FIFO_DEPTH && !tx_load && !stby
    |=> txcnt_ff == `USS_FIFO_DEPTH && !tx_push)
    else $error("byte taken into full transmit FIFO");
  rdf_cause_a: assert property ($rose(flag_ff[`USS_BIT_RDF]) && !$past(stby)
    |-> $past(above_rx))
    else $error("receive full set without level above trigger");
  idle_cause_a: assert property ($rose(flag_ff[`USS_BIT_DR]) |-> $past(below_rx)
    && $past(idle_cnt_ff) == `USS_IDLE_ETU - 4'd1)
    else $error("idle flag set early or above trigger");
  ro_bits_a: assert property (wr_status && !stby && !rx_pop && rxcnt != 5'd0 |=>
    $stable(status_w[3:2]))
    else $error("read-only error bits changed by write");
endmodule // uss_status

// >>> hdl/uss_sync3.sv
// Three-stage synchroniser for the receive line pin.
`timescale 1ns/100ps
module uss_sync3 (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic d,
  output logic q
);
  logic s1_ff, s2_ff, s3_ff, q_ff;

  // The line idles at mark, so every stage resets high.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
      q_ff <= 1'b1;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        q_ff <= s3_ff;
      end
    end
  end

  assign q = q_ff;
endmodule // uss_sync3

// >>> pkg/uss_params.svh
// Register offsets, field positions, reset values and counts of the serial status block.
`ifndef USS_PARAMS_SVH
`define USS_PARAMS_SVH
`define USS_OFF_STATUS 8'h00
`define USS_OFF_CTRL 8'h04
`define USS_OFF_TRIG 8'h08
`define USS_OFF_TXDATA 8'h0c
`define USS_STATUS_RST 16'h0060
`define USS_FLAG_RST 8'h60
`define USS_CLR_MASK 8'hf3
`define USS_BIT_ER 7
`define USS_BIT_TX_DONE_FLAG 6
`define USS_BIT_TX_FIFO_LOW_FLAG 5
`define USS_BIT_BRK 4
`define USS_BIT_RDF 1
`define USS_BIT_DR 0
`define USS_CTRL_TE 5
`define USS_CTRL_RE 4
`define USS_CTRL_STOP2 2
`define USS_CTRL_PEN 1
`define USS_CTRL_ODD 0
`define USS_CTRL_RST 8'h00
`define USS_CTRL_MASK 8'h37
`define USS_TRIG_TX 3:0
`define USS_TRIG_RX 11:8
`define USS_TRIG_RST 12'h101
`define USS_FIFO_DEPTH 5'd16
`define USS_IDLE_ETU 4'd15
`define USS_RESP_OKAY 2'b00
`define USS_RESP_SLVERR 2'b10
`endif

// >>> pkg/uss_pkg.sv
// Types shared by the serial status block.
package uss_pkg;
  typedef enum logic [2:0] {
    USS_REG_STATUS = 3'b000,
    USS_REG_CTRL = 3'b001,
    USS_REG_TRIG = 3'b010,
    USS_REG_TXDATA = 3'b011,
    USS_REG_NONE = 3'b100
  } uss_reg_type;
endpackage

// >>> verif/uart_fifo_status_flags_tb.sv
// Self-checking bench of the serial status block and its register slave.
`timescale 1ns/100ps
`include "uss_params.svh"
module uart_fifo_status_flags_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, standby = 1'b0, module_standby = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_push;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd;
  logic [7:0] tx_fifo_data, rx_char_data;
  logic tx_enable_bit, rx_enable_bit, two_stop, parity_enable, parity_odd_select;
  logic etu_tick, rx_line, rx_char_valid, rx_parity_bit, rx_stop_bit, rx_pop;
  logic tx_load, tx_char_end;
  int mismatches = 0, n_compared = 0, cyc = 0, n_push = 0;
  always #5 aclk = ~aclk;
  uss_status i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .standby, .module_standby,
    .rx_line, .etu_tick, .rx_char_valid, .rx_char_data, .rx_parity_bit, .rx_stop_bit,
    .rx_pop, .tx_load, .tx_char_end, .tx_push, .tx_fifo_data, .tx_enable_bit,
    .rx_enable_bit, .two_stop, .parity_enable, .parity_odd_select);
  uss_remote i_rem (.aclk, .aresetn, .etu_tick, .rx_line, .rx_char_valid, .rx_char_data,
    .rx_parity_bit, .rx_stop_bit, .rx_pop, .tx_load, .tx_char_end);
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (tx_push) n_push <= n_push + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      results();
    end
  end
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Both bus tasks start just after an edge and hold every request until its handshake.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
    // One spare edge keeps a following call from lowering and raising a ready in one step.
    @(posedge aclk);
  endtask
  task automatic rdr(input logic [7:0] a);
    logic done;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge aclk);
  endtask
  task automatic st(input logic [31:0] exp);
    rdr(`USS_OFF_STATUS);
    chk("status", rd, exp);
  endtask
  // Standby for one cycle reloads the flags and drops every read arming.
  task automatic pulse_standby();
    standby <= 1'b1;
    @(posedge aclk);
    standby <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    st(32'h60);
    rdr(`USS_OFF_TRIG);
    chk("trig", rd, 32'h101);
    $display("test reset done");
  endtask
  task automatic t_clear();
    wr(`USS_OFF_STATUS, 32'hff);
    st(32'h60);
    wr(`USS_OFF_STATUS, 32'hbf);
    st(32'h20);
    pulse_standby();
    wr(`USS_OFF_STATUS, 32'h0);
    st(32'h60);
    wr(`USS_OFF_STATUS, 32'h0);
    st(32'h0);
    $display("test clear done");
  endtask
  task automatic t_rx();
    wr(`USS_OFF_CTRL, 32'h16);
    chk("ctrl_pins", {tx_enable_bit, rx_enable_bit, two_stop, parity_enable,
      parity_odd_select}, 32'h0e);
    i_rem.send(8'h03, 1'b0, 1'b1);
    i_rem.send(8'h00, 1'b0, 1'b0);
    i_rem.send(8'h01, 1'b0, 1'b1);
    st(32'h1192);
    rdr(`USS_OFF_TXDATA);
    chk("rx_count", rd[12:8], 32'h3);
    i_rem.strobe(3'b100);
    st(32'h119a);
    wr(`USS_OFF_CTRL, 32'h0);
    st(32'h119a);
    i_rem.strobe(3'b100);
    st(32'h1096);
    wr(`USS_OFF_STATUS, 32'h0);
    st(32'h1006);
    i_rem.strobe(3'b100);
    st(32'h2);
    wr(`USS_OFF_STATUS, 32'h0);
    st(32'h0);
    $display("test receive done");
  endtask
  task automatic t_standby();
    for (int i = 0; i < 2; i++) begin
      st(32'h60 * i);
      wr(`USS_OFF_STATUS, 32'h0);
      wr(`USS_OFF_CTRL, 32'h37);
      wr(`USS_OFF_TRIG, 32'h0f0f);
      if (i == 0) standby <= 1'b1;
      else module_standby <= 1'b1;
      @(posedge aclk);
      standby <= 1'b0;
      module_standby <= 1'b0;
      repeat (2) @(posedge aclk);
      st(32'h60);
      rdr(`USS_OFF_CTRL);
      chk("ctrl", rd, 32'h0);
      rdr(`USS_OFF_TRIG);
      chk("trig", rd, 32'h101);
    end
    $display("test standby done");
  endtask
  task automatic t_tx();
    int n0;
    n0 = n_push;
    wr(`USS_OFF_CTRL, 32'h20);
    wr(`USS_OFF_TXDATA, 32'h10);
    st(32'h20);
    chk("tx_byte", tx_fifo_data, 32'h10);
    // Software here overruns the FIFO on purpose by one byte.
    for (int i = 1; i < 17; i++) wr(`USS_OFF_TXDATA, 32'h10 + i);
    st(32'h0);
    rdr(`USS_OFF_TXDATA);
    chk("tx_count", rd[4:0], 32'h10);
    chk("pushes", n_push - n0, 32'h10);
    chk("last_byte", tx_fifo_data, 32'h1f);
    repeat (15) i_rem.strobe(3'b010);
    st(32'h0);
    i_rem.strobe(3'b010);
    st(32'h20);
    i_rem.strobe(3'b001);
    st(32'h60);
    wr(`USS_OFF_TXDATA, 32'h55);
    st(32'h20);
    wr(`USS_OFF_CTRL, 32'h0);
    st(32'h60);
    $display("test transmit done");
  endtask
  // A break holds the line at space; idle timing is then run with and without a start edge.
  task automatic t_line();
    wr(`USS_OFF_TRIG, 32'h0401);
    wr(`USS_OFF_CTRL, 32'h10);
    i_rem.drive_line(1'b0);
    i_rem.send(8'h00, 1'b0, 1'b0);
    st(32'h01f8);
    wr(`USS_OFF_STATUS, 32'h0);
    st(32'h0118);
    i_rem.drive_line(1'b1);
    wr(`USS_OFF_STATUS, 32'h0);
    st(32'h0108);
    repeat (300) @(posedge aclk);
    st(32'h0109);
    wr(`USS_OFF_STATUS, 32'h0);
    i_rem.send(8'h00, 1'b0, 1'b1);
    i_rem.drive_line(1'b0);
    repeat (300) @(posedge aclk);
    st(32'h0108);
    i_rem.drive_line(1'b1);
    pulse_standby();
    $display("test line done");
  endtask
  task automatic t_bad();
    rdr(8'h10);
    chk("rresp", rs, 32'h2);
    chk("rdata", rd, 32'h0);
    wr(8'h10, 32'hff);
    chk("bresp", rs, 32'h2);
    st(32'h60);
    chk("okay", rs, 32'h0);
    s_axi_wstrb <= 4'he;
    wr(`USS_OFF_STATUS, 32'h0);
    s_axi_wstrb <= 4'hf;
    st(32'h60);
    $display("test unmapped done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_clear();
    t_rx();
    t_standby();
    t_tx();
    t_line();
    t_bad();
    results();
  end
endmodule // uart_fifo_status_flags_tb

// >>> verif/uss_remote.sv
// Behavioural far end of the serial line: arrivals, FIFO pops and transmit shifting.
`timescale 1ns/100ps
module uss_remote (
  input wire logic aclk,
  input wire logic aresetn,
  output logic etu_tick,
  output logic rx_line,
  output logic rx_char_valid,
  output logic [7:0] rx_char_data,
  output logic rx_parity_bit,
  output logic rx_stop_bit,
  output logic rx_pop,
  output logic tx_load,
  output logic tx_char_end
);
  logic [3:0] etu_ff = 4'h0;
  initial begin
    etu_tick = 1'b0;
    rx_line = 1'b1;
    rx_char_valid = 1'b0;
    rx_char_data = 8'h00;
    rx_parity_bit = 1'b0;
    rx_stop_bit = 1'b1;
    {rx_pop, tx_load, tx_char_end} = 3'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    etu_ff <= aresetn ? etu_ff + 4'h1 : 4'h0;
    etu_tick <= aresetn && (etu_ff == 4'hf);
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Only the first stop bit is handed over; a second one never reaches the checker.
  task automatic send(input logic [7:0] d, input logic p, input logic s);
    @(posedge aclk);
    rx_char_valid <= 1'b1;
    rx_char_data <= d;
    rx_parity_bit <= p;
    rx_stop_bit <= s;
    @(posedge aclk);
    rx_char_valid <= 1'b0;
    // Released fields show the inverse so that a stale sample cannot pass as data.
    rx_char_data <= ~d;
    rx_parity_bit <= ~p;
    rx_stop_bit <= ~s;
    repeat (3) @(posedge aclk);
  endtask
  // The strobe pattern is pop, load and character end, in that order.
  task automatic strobe(input logic [2:0] m);
    @(posedge aclk);
    {rx_pop, tx_load, tx_char_end} <= m;
    @(posedge aclk);
    {rx_pop, tx_load, tx_char_end} <= 3'h0;
    repeat (3) @(posedge aclk);
  endtask
  // The line idles at mark; holding it at space is how a break or a start bit looks.
  // The wait covers the block's three-stage synchroniser.
  task automatic drive_line(input logic v);
    @(posedge aclk);
    rx_line <= v;
    repeat (5) @(posedge aclk);
  endtask
endmodule // uss_remote
